//--- design/ubr_irq_frame_ready.sv
// interrupt status/enable, frame number and buffer-ready registers on apb
`timescale 1ns/1ps
module ubr_irq_frame_ready #(
    parameter bit DMA_BUILT_IN         = 1'b1,
    parameter bit ERROR_LOGIC_BUILT_IN = 1'b1
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // serial engine side
    input  ubr_pkg::ubr_evt_s      evt,
    input  ubr_pkg::ubr_tok_s      tok,
    input  wire logic [7:0]        endpoint_direction,
    output ubr_pkg::ubr_resp_s     resp,
    output logic [31:0]            buffer_ready,
    // interrupt
    output logic                   usb_irq
);
    import ubr_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [31:0] status_q, status_d;
    logic [31:0] enable_q, enable_d;
    logic [31:0] ready_q,  ready_d;
    logic [10:0] frame_q,  frame_d;
    logic [2:0]  uframe_q, uframe_d;
    logic        irq_q,    irq_d;
    logic [31:0] rdata_q,  rdata_d;
    logic        err_q,    err_d;
    ubr_resp_s   resp_q,   resp_d;

    logic        setup_ph;
    logic        access_ph;
    logic        wr_en;
    logic        rd_status;
    logic [31:0] build_mask;
    logic [31:0] status_vis;
    logic [31:0] set_vec;
    logic        hit;
    logic        pend_now;
    logic        pend_next;
    logic        drop_evt;
    logic [4:0]  tok_bit;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // bits of options not built in read as zero and never set
    // build options
    assign build_mask = UBR_STATUS_MASK
                      & ~(DMA_BUILT_IN ? 32'h0000_0000 : UBR_DMA_MASK)
                      & ~(ERROR_LOGIC_BUILT_IN ? 32'h0000_0000
                                               : UBR_ERR_MASK);
    assign setup_ph   = psel & ~penable;
    assign access_ph  = psel & penable;
    assign pready     = access_ph;             // zero wait states
    assign prdata     = rdata_q;
    assign pslverr    = access_ph & err_q;
    assign wr_en      = access_ph & pwrite & ~err_q;
    assign rd_status  = access_ph & ~pwrite & ~err_q
                      & (paddr == UBR_OFS_STATUS);
    assign hit        = (paddr == UBR_OFS_STATUS) | (paddr == UBR_OFS_FRAME)
                      | (paddr == UBR_OFS_ENABLE) | (paddr == UBR_OFS_READY);
    assign status_vis = status_q & build_mask;
    // flags set this cycle, including buffer processed pulses
    // done pulses of every ready bit, endpoint 0 at bit 31
    assign set_vec    = (evt.flag_set | (evt.buf_done & UBR_READY_MASK))
                      & build_mask;

    // read data is captured in the setup cycle and shown in access
    always_comb begin
        rdata_d = rdata_q;
        err_d   = err_q;
        if (setup_ph) begin
            err_d   = ~hit;
            rdata_d = UBR_RST_WORD;
            if (!pwrite) begin
                unique case (paddr)
                    // captured flags are those cleared later
                    UBR_OFS_STATUS: rdata_d = status_vis | set_vec;
                    UBR_OFS_FRAME: begin
                        rdata_d[UBR_FRAME_LSB +: 11] = frame_q;
                        rdata_d[UBR_UFRAME_LSB +: 3] = uframe_q;
                    end
                    UBR_OFS_ENABLE: rdata_d = enable_q & UBR_ENABLE_MASK
                                            & (build_mask | 32'h0000_0001);
                    UBR_OFS_READY:  rdata_d = ready_q & UBR_READY_MASK;
                    default:        rdata_d = UBR_RST_WORD;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // status and enable registers
    // ------------------------------------------------------------
    always_comb begin
        status_d = status_q;
        // read clears only the flags that were reported
        if (rd_status) begin
            status_d = status_d & ~rdata_q;
        end
        // new events win over the read-clear
        status_d = (status_d | set_vec) & build_mask;
        enable_d = enable_q;
        // enables per bit, bit 23 held at zero
        if (wr_en && (paddr == UBR_OFS_ENABLE)) begin
            enable_d = pwdata & UBR_ENABLE_MASK;
        end
    end

    // ------------------------------------------------------------
    // interrupt output
    // ------------------------------------------------------------
    // master gate
    assign pend_now  = enable_q[UBR_MASTER_BIT]
                     & |(status_q & enable_q & build_mask
                         & ~32'h0000_0001);
    assign pend_next = enable_d[UBR_MASTER_BIT]
                     & |(status_d & enable_d & build_mask
                         & ~32'h0000_0001);
    // an enabled set flag loses its flag or its enable this cycle
    // flag cleared by read or enable cleared by write
    assign drop_evt  = enable_q[UBR_MASTER_BIT]
                     & |(status_q & enable_q & build_mask
                         & ~32'h0000_0001 & ~(status_d & enable_d));

    always_comb begin
        // enable rising over a set flag raises pend_next
        irq_d = pend_next;
        // drop first for one cycle, then raise again if still true
        if (drop_evt && pend_now) begin
            irq_d = 1'b0;
        end
    end

    // single level output, rises on assertion
    assign usb_irq = irq_q;

    // ------------------------------------------------------------
    // frame and microframe counters
    // ------------------------------------------------------------
    always_comb begin
        frame_d  = frame_q;
        uframe_d = uframe_q;
        // new frame number restarts microframes, repeats count up
        if (evt.sof_valid) begin
            frame_d = evt.sof_frame;
            if (evt.sof_frame == frame_q) begin
                uframe_d = uframe_q + 3'h1;
            end else begin
                uframe_d = UBR_UFRAME_RST;
            end
        end
    end

    // ------------------------------------------------------------
    // buffer ready register and token answer
    // ------------------------------------------------------------
    always_comb begin
        // finished buffers lose their ready bit
        ready_d = ready_q & ~evt.buf_done;
        // buffer 0 bits 24-31, a software write wins over done
        if (wr_en && (paddr == UBR_OFS_READY)) begin
            ready_d = pwdata;
        end
        ready_d = ready_d & UBR_READY_MASK;
    end

    // buffer 0 of endpoint n sits at 31-n, buffer 1 at 23-n
    // endpoint 0 always uses its single buffer
    assign tok_bit = (tok.buf_sel && (tok.ep != 3'h0))
                   ? 5'(UBR_BUF1_TOP - int'(tok.ep))
                   : 5'(UBR_BUF0_TOP - int'(tok.ep));

    always_comb begin
        resp_d.valid = tok.valid;
        resp_d.is_in = tok.is_in;
        resp_d.nak   = ~ready_q[tok_bit];
        // a non-control endpoint only serves its configured direction
        if ((tok.ep != 3'h0) && (tok.is_in != endpoint_direction[tok.ep]))
        begin
            resp_d.nak = 1'b1;
        end
    end

    assign resp         = resp_q;
    assign buffer_ready = ready_q;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // everything, the interrupt included, starts low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= UBR_RST_WORD;
            enable_q <= UBR_RST_WORD;
            ready_q  <= UBR_RST_WORD;
            frame_q  <= UBR_FRAME_RST;
            uframe_q <= UBR_UFRAME_RST;
            irq_q    <= 1'b0;
            rdata_q  <= UBR_RST_WORD;
            err_q    <= 1'b0;
            resp_q   <= '0;
        end else begin
            status_q <= status_d;
            enable_q <= enable_d;
            ready_q  <= ready_d;
            frame_q  <= frame_d;
            uframe_q <= uframe_d;
            irq_q    <= irq_d;
            rdata_q  <= rdata_d;
            err_q    <= err_d;
            resp_q   <= resp_d;
        end
    end

endmodule : ubr_irq_frame_ready

//--- design/ubr_pkg.sv
// constants and types for the interrupt, frame and buffer-ready block
// Functional notes
// - one interrupt output, asserted by a low to high transition
// - interrupt output held low from reset until first assertion
// - interrupt when any status flag and its enable are set, master on
// - setting an enable over an already set flag asserts the interrupt
// - read-clear of an enabled flag drops interrupt unless another holds; code still drops it one cycle, then raises it
// - clearing an enable over a set flag drops interrupt unless another; code still drops it one cycle, then raises it
// - simultaneous drop and raise: go low first, then high again
// - enable bit 0 is the master enable gating every flag
// - enables 1-22 and 24-31 gate same status bit; 23 reserved; reset 0
// - status 31 set when endpoint 0 single buffer is processed
// - dma bits 5-6 and error bits 2-4 depend on build options
// - frame count in bits 18-28, microframe in 29-31, read-only, reset 0
// - frame from each start-of-frame token, microframe from extra tokens
// - a token to a buffer whose ready bit is clear gets a nak
// - ready buffer direction follows the endpoint direction bit
// - endpoint 0 has one buffer and one ready bit for both directions
// - ready bits 16-22 are buffer 1 of endpoints 7..1; 0-15 reserved
// - every status flag is cleared by a read of the status register
// - ready bits 24-31 are buffer 0 of endpoints 7..0; 31 is endpoint 0
package ubr_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] UBR_OFS_STATUS = 12'h108;
    localparam logic [11:0] UBR_OFS_FRAME  = 12'h10c;
    localparam logic [11:0] UBR_OFS_ENABLE = 12'h110;
    localparam logic [11:0] UBR_OFS_READY  = 12'h114;

    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int UBR_MASTER_BIT = 0;
    localparam int UBR_RESV_BIT   = 23;
    localparam int UBR_FRAME_LSB  = 18;
    localparam int UBR_UFRAME_LSB = 29;
    localparam int UBR_EP0_BIT    = 31;
    localparam int UBR_BUF0_TOP   = 31;
    localparam int UBR_BUF1_TOP   = 23;
    localparam logic [31:0] UBR_STATUS_MASK = 32'hff7f_fffe;
    localparam logic [31:0] UBR_ENABLE_MASK = 32'hff7f_ffff;
    localparam logic [31:0] UBR_READY_MASK  = 32'hff7f_0000;
    localparam logic [31:0] UBR_DMA_MASK    = 32'h0000_0060;
    localparam logic [31:0] UBR_ERR_MASK    = 32'h0000_001c;
    localparam logic [31:0] UBR_RST_WORD    = 32'h0000_0000;
    localparam logic [10:0] UBR_FRAME_RST   = 11'h000;
    localparam logic [2:0]  UBR_UFRAME_RST  = 3'h0;

    // events and token request from the serial engine
    typedef struct packed {
        logic [31:0] flag_set;   // one-cycle status events
        logic [31:0] buf_done;   // one-cycle buffer processed pulses
        logic        sof_valid;  // start-of-frame token seen
        logic [10:0] sof_frame;  // frame number in that token
    } ubr_evt_s;

    typedef struct packed {
        logic       valid;
        logic [2:0] ep;
        logic       buf_sel;     // 0 = buffer 0, 1 = buffer 1
        logic       is_in;       // 1 = IN token, 0 = OUT token
    } ubr_tok_s;

    typedef struct packed {
        logic valid;
        logic nak;
        logic is_in;
    } ubr_resp_s;

endpackage : ubr_pkg

//--- test/ubr_irq_frame_ready_asserts.sv
// port checker for the interrupt, frame and ready block
`timescale 1ns/1ps
module ubr_irq_frame_ready_asserts (
    // clock, reset and apb
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [11:0]   paddr,
    // serial engine side
    input ubr_pkg::ubr_evt_s  evt,
    input ubr_pkg::ubr_tok_s  tok,
    input wire logic [7:0]    endpoint_direction,
    input ubr_pkg::ubr_resp_s resp,
    input wire logic [31:0]   buffer_ready
);
    import ubr_pkg::*;
    logic       wr_rdy;
    logic       dir_bad;
    logic [4:0] tok_idx;
    // ready write, direction mismatch and addressed ready bit
    assign wr_rdy  = psel && penable && pwrite && paddr == UBR_OFS_READY;
    assign dir_bad = tok.ep != 3'h0 && tok.is_in != endpoint_direction[tok.ep];
    assign tok_idx = {1'b1, ~(tok.buf_sel && tok.ep != 3'h0), ~tok.ep};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------
    // properties
    // ----------
    resp_timing_a: assert property (tok.valid |=> resp.valid)
        else $error("token query not answered next cycle");
    resp_quiet_a: assert property (!tok.valid |=> !resp.valid)
        else $error("answer without a token query");
    nak_unready_a: assert property (
        tok.valid && !buffer_ready[tok_idx] |=> resp.nak)
        else $error("unready buffer not refused");
    nak_dir_a: assert property (tok.valid && dir_bad |=> resp.nak)
        else $error("wrong direction not refused");
    accept_ok_a: assert property (
        tok.valid && buffer_ready[tok_idx] && !dir_bad |=> !resp.nak)
        else $error("ready buffer refused");
    resp_dir_a: assert property (
        tok.valid |=> resp.is_in == $past(tok.is_in))
        else $error("answer direction differs from query");
    done_clear_a: assert property (
        |(evt.buf_done & buffer_ready) && !wr_rdy
        |=> (buffer_ready & $past(evt.buf_done)) == 32'h0)
        else $error("processed buffer still ready");
    resv_ready_a: assert property (
        (buffer_ready & ~UBR_READY_MASK) == 32'h0)
        else $error("reserved ready bit set");
endmodule : ubr_irq_frame_ready_asserts

bind ubr_irq_frame_ready ubr_irq_frame_ready_asserts u_chk (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .evt, .tok,
    .endpoint_direction, .resp, .buffer_ready);

//--- test/ubr_irq_frame_ready_tb.sv
// self-checking bench for the interrupt, frame and ready block
`timescale 1ns/1ps
module ubr_irq_frame_ready_tb;
    import ubr_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [7:0]  endpoint_direction = 8'h02;
    logic        pready, pslverr, usb_irq;
    logic [31:0] prdata, buffer_ready, rnd;
    ubr_evt_s    evt;
    ubr_tok_s    tok;
    ubr_resp_s   resp;
    logic [32:0] exp_rd[$];
    logic        exp_nak[$];
    int          mismatches = 0;
    int          checks = 0;
    int          seed = 52;
    // clock, design and engine model
    always #5 pclk = ~pclk;
    ubr_irq_frame_ready dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pready, .prdata, .pslverr, .evt, .tok,
        .endpoint_direction, .resp, .buffer_ready, .usb_irq);
    ubr_se_model se (.pclk, .evt, .tok);
    task automatic chk(input string n, input logic [32:0] e, g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done
    // apb transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never gets an answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        exp_rd.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic irq_at(input int n, input logic e);
        repeat (n) @(posedge pclk);
        #1 chk("irq", e, usb_irq);
    endtask : irq_at
    task automatic tk(input logic [2:0] e, input logic b, i, n);
        exp_nak.push_back(n);
        se.token(e, b, i);
    endtask : tk
    // result watcher
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk("read", exp_rd.pop_front(), {pslverr, prdata});
        if (resp.valid === 1'b1)
            chk("nak", exp_nak.pop_front(), resp.nak);
    end
    // watchdog
    initial begin
        repeat (5000) @(posedge pclk);
        mismatches++;
        test_done();
    end
    // ----------
    // stimulus
    // ----------
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        irq_at(1, 1'b0);
        rd(UBR_OFS_STATUS, 33'h0);
        rd(UBR_OFS_FRAME, 33'h0);
        rd(UBR_OFS_ENABLE, 33'h0);
        rd(UBR_OFS_READY, 33'h0);
        rd(12'h118, {1'b1, 32'h0});
        apb(1'b1, UBR_OFS_ENABLE, 32'hffff_ffff);
        rd(UBR_OFS_ENABLE, {1'b0, UBR_ENABLE_MASK});
        rnd = $random(seed);
        apb(1'b1, UBR_OFS_READY, rnd);
        rd(UBR_OFS_READY, {1'b0, rnd & UBR_READY_MASK});
        apb(1'b1, UBR_OFS_ENABLE, 32'h100);
        se.pulse(32'h300, 32'h0);
        irq_at(2, 1'b0);
        apb(1'b1, UBR_OFS_ENABLE, 32'h101);
        irq_at(2, 1'b1);
        apb(1'b1, UBR_OFS_ENABLE, 32'h001);
        irq_at(2, 1'b0);
        apb(1'b1, UBR_OFS_ENABLE, 32'h301);
        irq_at(2, 1'b1);
        apb(1'b1, UBR_OFS_ENABLE, 32'h201);
        irq_at(0, 1'b0);
        irq_at(1, 1'b1);
        rd(UBR_OFS_STATUS, {1'b0, 32'h300});
        irq_at(2, 1'b0);
        rd(UBR_OFS_STATUS, 33'h0);
        apb(1'b1, UBR_OFS_READY, 32'h0);
        tk(3'd1, 1'b0, 1'b1, 1'b1);
        apb(1'b1, UBR_OFS_READY, 32'hc000_0000);
        tk(3'd1, 1'b0, 1'b1, 1'b0);
        tk(3'd1, 1'b0, 1'b0, 1'b1);
        tk(3'd1, 1'b1, 1'b1, 1'b1);
        tk(3'd0, 1'b1, 1'b0, 1'b0);
        apb(1'b1, UBR_OFS_ENABLE, 32'h8000_0001);
        se.pulse(32'h0, 32'h8000_0000);
        irq_at(2, 1'b1);
        rd(UBR_OFS_READY, {1'b0, 32'h4000_0000});
        rd(UBR_OFS_STATUS, {1'b0, 32'h8000_0000});
        // start-of-frame interrupt left disabled during the tokens
        se.sof(11'd5);
        rd(UBR_OFS_FRAME, {1'b0, 3'd0, 11'd5, 18'h0});
        for (int i = 0; i < 8; i++) begin
            se.sof(11'h7ff);
            rd(UBR_OFS_FRAME, {1'b0, i[2:0], 11'h7ff, 18'h0});
        end
        test_done();
    end
endmodule : ubr_irq_frame_ready_tb

//--- test/ubr_se_model.sv
// serial engine stand-in: status events, frame tokens, token queries
`timescale 1ns/1ps
module ubr_se_model (
    // clock
    input wire logic          pclk,
    // engine outputs
    output ubr_pkg::ubr_evt_s evt,
    output ubr_pkg::ubr_tok_s tok
);
    import ubr_pkg::*;
    // idle engine
    initial begin
        evt = '0;
        tok = '0;
    end
    // one-cycle status and buffer-done pulses
    task automatic pulse(input logic [31:0] f, input logic [31:0] d);
        @(posedge pclk);
        evt.flag_set <= f;
        evt.buf_done <= d;
        @(posedge pclk);
        evt.flag_set <= '0;
        evt.buf_done <= '0;
    endtask : pulse
    task automatic sof(input logic [10:0] n);
        @(posedge pclk);
        evt.sof_valid <= 1'b1;
        evt.sof_frame <= n;
        @(posedge pclk);
        evt.sof_valid <= 1'b0;
        evt.sof_frame <= ~n; // number no longer held
        @(posedge pclk);
    endtask : sof
    task automatic token(input logic [2:0] e, input logic b, input logic i);
        @(posedge pclk);
        tok <= '{1'b1, e, b, i};
        @(posedge pclk);
        tok <= '{1'b0, ~e, ~b, ~i}; // released fields scrambled
    endtask : token
endmodule : ubr_se_model
